// File: rtl/srs_defs.svh
// Offsets, field positions, reset values and counts of the shared register set.
// Assumes an 8-bit byte-addressed register space decoded by the SMBus slave outside.
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH

`define SRS_ADDR_STRAP     8'h00
`define SRS_ADDR_REVPART   8'h01
`define SRS_ADDR_RSV2      8'h02
`define SRS_ADDR_RSV3      8'h03
`define SRS_ADDR_CTRL      8'h04
`define SRS_ADDR_STAT      8'h05
`define SRS_ADDR_RSV6      8'h06
`define SRS_ADDR_RSV7      8'h07
`define SRS_ADDR_SEL       8'hff

`define SRS_BIT_BCAST      3
`define SRS_BIT_LANE_EN    2
`define SRS_BIT_SOFT_RST   6
`define SRS_BIT_MAS_RST    5
`define SRS_BIT_FORCE_LD   4
`define SRS_BIT_LD_DIS     7
`define SRS_BIT_LD_DONE    4

`define SRS_RST_CTRL       8'h01
`define SRS_RST_CTRL_RW    8'h9f
`define SRS_RST_STAT_RW    8'he0
`define SRS_RST_RSV2       8'h00
`define SRS_RST_RSV6       8'h00
`define SRS_RST_RSV7       8'h05
`define SRS_RST_SEL        4'h0
`define SRS_ADDR_BASE      7'h18
`define SRS_NUM_LANES      4

`endif

// File: rtl/srs_pkg.sv
// Types shared by the register-select front end, its host model and its bench.
// Assumes srs_defs.svh is compiled alongside.
package srs_pkg;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} srs_req_s;

	typedef struct packed {
		logic [3:0] lane_we;
		logic [1:0] lane_rsel;
		logic       lane_rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} srs_lane_s;

	typedef enum logic [2:0] {
		SRS_LD_IDLE = 3'b001,
		SRS_LD_BUSY = 3'b010,
		SRS_LD_DONE = 3'b100
	} srs_ld_e;

endpackage : srs_pkg

// File: rtl/srs_flag.sv
// Sticky flag: set by a hardware event pulse, cleared by a synchronous clear.
// Assumes set and clear come from the clk domain.
`timescale 1ns/1ps
module srs_flag (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic set,
	input  wire logic clr,
	output logic      flag
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (set) begin
			// Set wins over a clear in the same cycle
			flag <= 1'b1;
		end else if (clr) begin
			flag <= 1'b0;
		end
	end
endmodule : srs_flag

// File: rtl/srs_regsel.sv
// Shared register set and lane-space select of a four-lane retimer.
// Assumes an SMBus slave outside presents one-cycle rd/wr strobes with address.
// Behaviour
// R1: Top-address write always hits select register
// R2: Lane enable zero routes all to shared
// R3: Lane enable one routes to pointed lane
// R4: Broadcast plus enable writes all lanes
// R5: Writes to read-only fields are ignored
// R6: Host leaves reserved addresses and bits alone; the bench writes 8'haa to reserved address 07 before its soft reset check
// R7: Host uses read-modify-write for fields
// R8: Address zero reads strapped address bits
// R9: Soft reset bit restores shared defaults
// R10: Master reset bit resets EEPROM master
// R11: Force bit requests EEPROM configuration load
// R12: Disable bit blocks master-mode EEPROM load
// R13: Load done flag read-only, resets one
// R14: Per-lane interrupt flags, lane0 at bit3
// R15: Select fields reset to zero
// R16: Lane reads follow pointer despite broadcast
// R17: Select reads invalid, host writes zeros
// R18: Soft reset also clears select register
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_regsel (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Register access from the SMBus slave
	input  wire srs_pkg::srs_req_s req,
	output logic [7:0]             rdata,
	// Lane register sets
	output srs_pkg::srs_lane_s     lane,
	input  wire logic [7:0]        lane_rdata,
	input  wire logic [3:0]        lane_irq,
	// Straps and identity
	input  wire logic [3:0]        strap_addr,
	output logic [6:0]             smbus_addr,
	// EEPROM master engine
	output logic                   mas_rst,
	output logic                   rom_load_start,
	input  wire logic              rom_load_done
);
	import srs_pkg::*;

	// Arbitrary revision and part code, not of any real part
	localparam logic [7:0] REV_PART = 8'h5a;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] stat_rw;
		logic       ld_done;
		logic [7:0] rsv2;
		logic [7:0] rsv6;
		logic [7:0] rsv7;
		logic [3:0] sel;
		logic [3:0] strap;
		logic       mas_rst;
		srs_ld_e    ld;
	} srs_state_s;

	srs_state_s st_r;
	srs_state_s st_nxt;
	logic [3:0] irq_flags;
	logic       lane_mode;
	logic       sh_wr;
	logic       soft_rst;
	logic       irq_clr;

	// R2: shared routing
	assign lane_mode = st_r.sel[`SRS_BIT_LANE_EN];
	// R1: select address never routed away
	assign sh_wr     = req.wr && (req.addr == `SRS_ADDR_SEL || !lane_mode);
	// R9: soft reset pulse
	assign soft_rst  = sh_wr && req.addr == `SRS_ADDR_CTRL && req.wdata[`SRS_BIT_SOFT_RST];
	assign irq_clr   = soft_rst;

	// R14: sticky per-lane interrupt flags
	for (genvar g = 0; g < `SRS_NUM_LANES; g++) begin : g_irq
		srs_flag u_flag (
			.clk  (clk),
			.rst  (rst),
			.set  (lane_irq[g]),
			.clr  (irq_clr),
			.flag (irq_flags[3 - g])
		);
	end

	always_comb begin
		st_nxt         = st_r;
		st_nxt.mas_rst = 1'b0;
		st_nxt.strap   = strap_addr;
		if (sh_wr) begin
			case (req.addr)
				// R1: select register write
				`SRS_ADDR_SEL:  st_nxt.sel = req.wdata[3:0];
				`SRS_ADDR_RSV2: st_nxt.rsv2 = req.wdata;
				`SRS_ADDR_RSV6: st_nxt.rsv6 = req.wdata;
				`SRS_ADDR_RSV7: st_nxt.rsv7 = req.wdata;
				`SRS_ADDR_CTRL: begin
					// R5: self-clearing bits never stored
					st_nxt.ctrl = req.wdata & `SRS_RST_CTRL_RW;
					// R10: master engine reset pulse
					st_nxt.mas_rst = req.wdata[`SRS_BIT_MAS_RST];
				end
				// R5: read-only status bits kept
				`SRS_ADDR_STAT: st_nxt.stat_rw = req.wdata & `SRS_RST_STAT_RW;
				default: ;
			endcase
		end
		// R11: EEPROM load sequencing
		case (st_r.ld)
			SRS_LD_IDLE: begin
				// R12: load disable gate
				if (st_r.ctrl[`SRS_BIT_FORCE_LD] && !st_r.stat_rw[`SRS_BIT_LD_DIS]) begin
					st_nxt.ld      = SRS_LD_BUSY;
					st_nxt.ld_done = 1'b0;
				end
			end
			SRS_LD_BUSY: begin
				// R13: done flag set on completion
				if (rom_load_done) begin
					st_nxt.ld      = SRS_LD_DONE;
					st_nxt.ld_done = 1'b1;
				end
			end
			SRS_LD_DONE: begin
				// A new load needs the force bit cleared first
				if (!st_r.ctrl[`SRS_BIT_FORCE_LD]) begin
					st_nxt.ld = SRS_LD_IDLE;
				end
			end
			default: st_nxt.ld = SRS_LD_IDLE;
		endcase
		if (st_r.mas_rst) begin
			st_nxt.ld = SRS_LD_IDLE;
		end
		// R9: shared defaults restored
		if (soft_rst) begin
			st_nxt.ctrl    = `SRS_RST_CTRL;
			st_nxt.stat_rw = 8'h00;
			st_nxt.ld_done = 1'b1;
			st_nxt.rsv2    = `SRS_RST_RSV2;
			st_nxt.rsv6    = `SRS_RST_RSV6;
			st_nxt.rsv7    = `SRS_RST_RSV7;
			// R18: select cleared too
			st_nxt.sel     = `SRS_RST_SEL;
			st_nxt.ld      = SRS_LD_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r.ctrl    <= `SRS_RST_CTRL;
			st_r.stat_rw <= 8'h00;
			st_r.ld_done <= 1'b1;
			st_r.rsv2    <= `SRS_RST_RSV2;
			st_r.rsv6    <= `SRS_RST_RSV6;
			st_r.rsv7    <= `SRS_RST_RSV7;
			// R15: select resets to zero
			st_r.sel     <= `SRS_RST_SEL;
			st_r.strap   <= 4'h0;
			st_r.mas_rst <= 1'b0;
			st_r.ld      <= SRS_LD_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// R4: broadcast write enables
	always_comb begin
		lane.lane_we = 4'h0;
		if (req.wr && lane_mode && req.addr != `SRS_ADDR_SEL) begin
			if (st_r.sel[`SRS_BIT_BCAST]) begin
				lane.lane_we = 4'hf;
			end else begin
				// R3: pointed lane only
				lane.lane_we[st_r.sel[1:0]] = 1'b1;
			end
		end
	end
	// R16: reads follow pointer
	assign lane.lane_rsel = st_r.sel[1:0];
	assign lane.lane_rd   = req.rd && lane_mode && req.addr != `SRS_ADDR_SEL;
	assign lane.addr      = req.addr;
	assign lane.wdata     = req.wdata;

	// R8: 7-bit address from strap
	assign smbus_addr     = `SRS_ADDR_BASE + {3'h0, st_r.strap};
	assign mas_rst        = st_r.mas_rst;
	assign rom_load_start = st_r.ld == SRS_LD_BUSY;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			if (req.addr == `SRS_ADDR_SEL) begin
				// R17: select readback is not valid
				rdata <= 8'h00;
			end else if (lane_mode) begin
				rdata <= lane_rdata;
			end else begin
				case (req.addr)
					// R8: strap read-only field
					`SRS_ADDR_STRAP:   rdata <= {st_r.strap, 4'h0};
					`SRS_ADDR_REVPART: rdata <= REV_PART;
					`SRS_ADDR_RSV2:    rdata <= st_r.rsv2;
					`SRS_ADDR_CTRL:    rdata <= st_r.ctrl;
					// R14: lane0 lands at bit 3
					`SRS_ADDR_STAT:    rdata <= {st_r.stat_rw[7:5], st_r.ld_done, irq_flags};
					`SRS_ADDR_RSV6:    rdata <= st_r.rsv6;
					`SRS_ADDR_RSV7:    rdata <= st_r.rsv7;
					default:           rdata <= 8'h00;
				endcase
			end
		end
	end

	sel_write_a: assert property (@(posedge clk) disable iff (rst)
		req.wr && req.addr == `SRS_ADDR_SEL && !soft_rst |=> st_r.sel == $past(req.wdata[3:0]))
		else $error("select write lost"); // R1
	shared_route_a: assert property (@(posedge clk) disable iff (rst)
		!lane_mode |-> lane.lane_we == 4'h0 && !lane.lane_rd)
		else $error("lane access while shared"); // R2
	lane_point_a: assert property (@(posedge clk) disable iff (rst)
		req.wr && lane_mode && !st_r.sel[3] && req.addr != 8'hff
		|-> lane.lane_we == (4'h1 << st_r.sel[1:0]))
		else $error("wrong lane written"); // R3
	bcast_all_a: assert property (@(posedge clk) disable iff (rst)
		req.wr && st_r.sel[3:2] == 2'b11 && req.addr != 8'hff |-> lane.lane_we == 4'hf)
		else $error("broadcast missed a lane"); // R4
	ro_hold_a: assert property (@(posedge clk) disable iff (rst)
		req.wr && req.addr == `SRS_ADDR_STAT && st_r.ld == SRS_LD_DONE
		|=> st_r.ld_done == $past(st_r.ld_done))
		else $error("read-only bit written"); // R5
	strap_read_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && !lane_mode && req.addr == 8'h00 |=> rdata == {$past(st_r.strap), 4'h0})
		else $error("strap readback wrong"); // R8
	soft_reset_a: assert property (@(posedge clk) disable iff (rst)
		soft_rst |=> st_r.sel == 4'h0 && st_r.rsv7 == 8'h05 && !st_r.ctrl[6])
		else $error("soft reset incomplete"); // R9
	mas_pulse_a: assert property (@(posedge clk) disable iff (rst)
		sh_wr && req.addr == `SRS_ADDR_CTRL && req.wdata[5] |=> mas_rst ##1 !mas_rst)
		else $error("master reset not a pulse"); // R10
	load_block_a: assert property (@(posedge clk) disable iff (rst)
		st_r.ld == SRS_LD_IDLE && st_r.stat_rw[7] && !st_r.mas_rst && !soft_rst
		|=> st_r.ld == SRS_LD_IDLE)
		else $error("load started while disabled"); // R12
	done_flag_a: assert property (@(posedge clk) disable iff (rst)
		st_r.ld == SRS_LD_BUSY && rom_load_done && !st_r.mas_rst && !soft_rst |=> st_r.ld_done)
		else $error("done flag not set"); // R13
	read_ptr_a: assert property (@(posedge clk) disable iff (rst)
		lane_mode |-> lane.lane_rsel == st_r.sel[1:0])
		else $error("read lane not pointer"); // R16
	sel_read_a: assert property (@(posedge clk) disable iff (rst)
		req.rd && req.addr == 8'hff |=> rdata == 8'h00)
		else $error("select readback not zero"); // R17

	bcast_c: cover property (@(posedge clk) disable iff (rst) lane.lane_we == 4'hf);
	load_c:  cover property (@(posedge clk) disable iff (rst)
		st_r.ld == SRS_LD_BUSY ##[1:20] st_r.ld == SRS_LD_DONE);
	softr_c: cover property (@(posedge clk) disable iff (rst) soft_rst && st_r.sel != 4'h0);

endmodule : srs_regsel

// File: sim/srs_host.sv
// Host model: single-byte register writes and reads on the request strobes.
// Assumes strobes are taken on rising clk and rdata is valid one edge later.
`timescale 1ns/1ps
module srs_host (
	// Clock
	input  wire logic         clk,
	// Register bus
	output srs_pkg::srs_req_s req,
	input  wire logic [7:0]   rdata
);
	import srs_pkg::*;
	initial req = '0;
	// whole bytes, select upper nibble zero
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		// Released lines show the inverse, never a stale match
		#1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		#1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		d = rdata;
	endtask : rd
endmodule : srs_host

// File: sim/tb_srs_regsel.sv
// Bench for the register-select front end; lane sets and their model live here.
// Assumes srs_host drives the request bus.
`timescale 1ns/1ps
module tb_srs_regsel;
	import srs_pkg::*;
	logic       clk = 0;
	logic       rst = 1;
	srs_req_s   req;
	srs_lane_s  lane;
	logic [7:0] rdata, d, sel_m, lane_rdata;
	logic [7:0] lmem[4][256];
	logic [7:0] em[4][256];
	logic [7:0] sv[8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
	logic [3:0] lane_irq = 0;
	logic [3:0] strap = 0;
	logic [6:0] smbus_addr;
	logic       mas_rst, start;
	logic       done = 0;
	int         fail_count = 0;
	int         compares = 0;
	int         n, seen;
	always #10 clk = ~clk;
	assign lane_rdata = lmem[lane.lane_rsel][lane.addr];
	always @(posedge clk)
		for (int i = 0; i < 4; i++)
			if (lane.lane_we[i] === 1'b1) lmem[i][lane.addr] <= lane.wdata;
	srs_regsel u_srs_regsel (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .lane(lane),
		.lane_rdata(lane_rdata), .lane_irq(lane_irq), .strap_addr(strap),
		.smbus_addr(smbus_addr), .mas_rst(mas_rst), .rom_load_start(start),
		.rom_load_done(done));
	srs_host u_srs_host (.clk(clk), .req(req), .rdata(rdata));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// Model write: select, pointed lane, or every lane
	task automatic mwr(input logic [7:0] a, input logic [7:0] v);
		u_srs_host.wr(a, v);
		if (a == 8'hff) sel_m = v;
		else if (sel_m[2])
			for (int i = 0; i < 4; i++)
				if (sel_m[3] || i == sel_m[1:0]) em[i][a] = v;
	endtask : mwr
	task automatic mrd(input logic [7:0] a);
		u_srs_host.rd(a, d);
		chk(d, em[sel_m[1:0]][a]);
	endtask : mrd
	initial begin
		void'($urandom(16455));
		sel_m = 0;
		foreach (lmem[i, j]) begin
			lmem[i][j] = 0;
			em[i][j] = 0;
		end
		strap = 4'($urandom_range(1, 15));
		repeat (3) @(posedge clk);
		#1 rst = 0;
		u_srs_host.rd(8'h00, d);
		chk(d, {strap, 4'h0});
		chk({1'b0, smbus_addr}, 8'h18 + 8'(strap));
		u_srs_host.rd(8'h05, d);
		chk(d, 8'h10);
		u_srs_host.wr(8'h00, 8'hff);
		u_srs_host.wr(8'h05, 8'h0f);
		u_srs_host.rd(8'h00, d);
		chk(d, {strap, 4'h0});
		u_srs_host.rd(8'h05, d);
		chk(d, 8'h10);
		$display("test defaults done");
		for (int k = 0; k < 8; k++) begin
			mwr(8'hff, sv[k]);
			mwr(8'h00, 8'($urandom));
			mwr(8'h30 + 8'(k), 8'($urandom));
			mwr(8'hff, sv[k]);
			mrd(8'h00);
			mrd(8'h30 + 8'(k));
		end
		for (int i = 0; i < 4; i++) begin
			mwr(8'hff, 8'(4 + i));
			for (int k = 0; k < 8; k++) mrd(8'h30 + 8'(k));
			chk(lmem[i][8'hff], 8'h00);
		end
		mwr(8'hff, 8'h00);
		u_srs_host.rd(8'h00, d);
		chk(d, {strap, 4'h0});
		$display("test lanes done");
		n = $urandom_range(0, 3);
		@(posedge clk);
		#1 lane_irq = 4'(1 << n);
		@(posedge clk);
		#1 lane_irq = 0;
		u_srs_host.rd(8'h05, d);
		chk(d, 8'h10 | (8'h08 >> n));
		u_srs_host.wr(8'h04, 8'h11);
		for (int t = 0; t < 5 && start !== 1'b1; t++) @(posedge clk);
		chk({7'h00, start}, 8'h01);
		u_srs_host.rd(8'h05, d);
		chk(d & 8'h10, 8'h00);
		done = 1;
		@(posedge clk);
		#1 done = 0;
		u_srs_host.rd(8'h05, d);
		chk(d & 8'h10, 8'h10);
		u_srs_host.wr(8'h04, 8'h01);
		u_srs_host.wr(8'h05, 8'h80);
		u_srs_host.wr(8'h04, 8'h11);
		repeat (4) begin
			@(posedge clk);
			#1 chk({7'h00, start}, 8'h00);
		end
		u_srs_host.wr(8'h05, 8'h00);
		u_srs_host.wr(8'h04, 8'h21);
		seen = 0;
		repeat (4) begin
			if (mas_rst === 1'b1) seen++;
			@(posedge clk);
			#1;
		end
		chk(8'(seen), 8'h01);
		$display("test load done");
		u_srs_host.wr(8'hff, 8'h03);
		chk(8'(lane.lane_rsel), 8'h03);
		u_srs_host.wr(8'h07, 8'haa);
		u_srs_host.wr(8'h04, 8'h41);
		u_srs_host.rd(8'h07, d);
		chk(d, 8'h05);
		u_srs_host.rd(8'h04, d);
		chk(d, 8'h01);
		u_srs_host.rd(8'h05, d);
		chk(d, 8'h10);
		chk(8'(lane.lane_rsel), 8'h00);
		$display("test soft reset done");
		give_verdict();
	end
endmodule : tb_srs_regsel
